/* File: include/port_group_pkg.sv */
// Package with register map, field layout and types of the port group controller.
package port_group_pkg;

  localparam int          PINS_PER_GROUP   = 8;
  localparam int          MAX_GROUPS       = 13;
  localparam int          ADDR_W           = 8;
  localparam int          REGS_PER_GROUP   = 8;

  // Byte offsets inside one group's window; group g sits at g * GROUP_STRIDE.
  localparam logic [7:0]  OFS_DATA         = 8'h00;
  localparam logic [7:0]  OFS_IO_ENABLE    = 8'h04;
  localparam logic [7:0]  OFS_PULL         = 8'h08;
  localparam logic [7:0]  OFS_IRQ_FLAGS    = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_CTRL     = 8'h10;
  localparam logic [7:0]  OFS_DEBOUNCE     = 8'h14;
  localparam logic [7:0]  OFS_MODE         = 8'h18;
  localparam logic [7:0]  OFS_FUNCTION     = 8'h1C;
  localparam logic [7:0]  GROUP_STRIDE     = 8'h20;
  localparam logic [7:0]  ADDR_CLOCK_CTRL  = 8'hF0;
  localparam logic [7:0]  ADDR_GROUP_SUM   = 8'hF4;

  localparam int          HI_LSB           = 8;
  localparam int          DIV_LSB          = 4;
  localparam int          KEY_LSB          = 2;
  localparam int          SRC_LSB          = 0;
  localparam int          DBG_BIT          = 8;
  localparam int          DIV_W            = 4;
  localparam int          FN_W             = 2;
  localparam logic [15:0] CLKCTRL_MASK     = 16'h01FF;
  localparam logic [15:0] RESET_WORD       = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

  localparam logic [1:0]  SRC_INTERNAL     = 2'h0;
  localparam logic [1:0]  SRC_LOW_SPEED    = 2'h1;
  localparam logic [1:0]  SRC_HIGH_SPEED   = 2'h2;
  localparam logic [1:0]  SRC_EXTERNAL     = 2'h3;
  localparam logic [1:0]  KEY_OFF          = 2'h0;
  localparam logic [1:0]  KEY_TWO          = 2'h1;
  localparam logic [1:0]  KEY_THREE        = 2'h2;
  localparam logic [1:0]  KEY_FOUR         = 2'h3;
  localparam logic [3:0]  DIV_MAX          = 4'hF;
  localparam int          FILTER_STAGES    = 3;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] drive_en;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
  } pad_ctrl_t;

  typedef struct packed {
    logic [1:0] source;
    logic [3:0] divider;
    logic       debug_run;
    logic [1:0] key_cfg;
  } clk_cfg_t;

endpackage

/* File: hdl/port_group_control.sv */
// Port group pin controller with Avalon-MM register slave, debounce and key-entry reset.
`timescale 1ns/1ps

module port_group_control #(
  parameter int          GROUPS      = 4,
  parameter logic [3:0]  SRC_PRESENT = 4'hF,
  parameter logic [12:0] IRQ_GROUPS  = 13'h1FFF
) (
  input  wire logic                                        clk,
  input  wire logic                                        arst_n,
  input  wire logic [port_group_pkg::ADDR_W-1:0]           avs_address,
  input  wire logic                                        avs_read,
  input  wire logic                                        avs_write,
  input  wire logic [31:0]                                 avs_writedata,
  input  wire logic [3:0]                                  avs_byteenable,
  output logic      [31:0]                                 avs_readdata,
  output logic                                             avs_waitrequest,
  input  wire logic                                        protect_unlocked,
  input  wire logic                                        debug_mode,
  input  wire logic [3:0]                                  source_ticks,
  input  wire logic [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] pad_in,
  output logic      [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] pad_out,
  output logic      [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] pad_oe,
  output logic      [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] pad_pull_en,
  output logic      [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] pad_pull_up,
  input  wire logic [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] periph_out,
  input  wire logic [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] periph_oe,
  output logic      [GROUPS*port_group_pkg::PINS_PER_GROUP-1:0] periph_in,
  output logic      [GROUPS*port_group_pkg::PINS_PER_GROUP*2-1:0] function_code,
  output logic      [GROUPS-1:0]                           irq_out,
  output logic                                             key_reset_req
);
  import port_group_pkg::*;

  localparam int NPINS = GROUPS * PINS_PER_GROUP;

  logic [7:0]   out_level_r          [GROUPS];
  logic [7:0]   input_enable_bits_r  [GROUPS];
  logic [7:0]   output_enable_bits_r [GROUPS];
  logic [7:0]   pull_direction_r     [GROUPS];
  logic [7:0]   pull_enable_r        [GROUPS];
  logic [7:0]   pin_irq_flag_r       [GROUPS];
  logic [7:0]   irq_edge_select_r    [GROUPS];
  logic [7:0]   pin_irq_enable_r     [GROUPS];
  logic [7:0]   debounce_enable_r    [GROUPS];
  logic [7:0]   peripheral_mode_r    [GROUPS];
  logic [15:0]  function_sel_r       [GROUPS];
  clk_cfg_t     clk_cfg_r;
  logic [NPINS-1:0] sync1_r;
  logic [NPINS-1:0] sync2_r;
  logic [NPINS-1:0] sync3_r;
  logic [NPINS-1:0] clean_r;
  logic [NPINS-1:0] filt_a_r;
  logic [NPINS-1:0] filt_b_r;
  logic [NPINS-1:0] filt_c_r;
  logic [NPINS-1:0] filt_r;
  logic [NPINS-1:0] level_prev_r;
  logic [15:0]  div_cnt_r;
  logic         tick_prev_r;
  logic         ack_r;
  logic [31:0]  rdata_nxt;

  logic [NPINS-1:0] pin_level;
  logic [NPINS-1:0] filtered;
  logic             div_tick;
  logic             src_tick;
  logic             clk_run;
  logic             req;
  logic [7:0]       grp_idx;
  logic [7:0]       reg_ofs;
  logic             grp_hit;
  logic [GROUPS-1:0] sum_bits;
  logic [15:0]      wmask;
  logic [15:0]      wdat;

  assign req     = (avs_read || avs_write) && !ack_r;
  assign grp_idx = avs_address / GROUP_STRIDE;
  assign reg_ofs = avs_address % GROUP_STRIDE;
  assign grp_hit = (grp_idx < 8'(GROUPS));
  assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat    = avs_writedata[15:0];

  // One wait cycle per access: read data is taken on the edge where ack_r is low, a write on the edge where it is high.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  always_comb
  begin
    avs_waitrequest = !ack_r;
  end

  // Debounce clock: selected source ticks, divided, gated in debug mode.
  always_comb
  begin
    src_tick = 1'b0;
    if (SRC_PRESENT[clk_cfg_r.source])
      src_tick = source_ticks[clk_cfg_r.source];
    clk_run = !debug_mode || clk_cfg_r.debug_run;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt_r   <= RESET_WORD;
      tick_prev_r <= 1'b0;
    end
    else
    begin
      tick_prev_r <= src_tick && clk_run;
      if (src_tick && clk_run)
        div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // External source is undivided; otherwise a tick every 2^divider source ticks.
  always_comb
  begin
    if (clk_cfg_r.source == SRC_EXTERNAL || clk_cfg_r.divider == 4'h0)
      div_tick = tick_prev_r;
    else
      div_tick = tick_prev_r &&
                 ((div_cnt_r & ((16'h0001 << clk_cfg_r.divider) - 16'h0001)) == 16'h0000);
  end

  // Pins pass three flops; a change counts when the second and third agree.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      clean_r <= '0;
    end
    else
    begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < NPINS; i++)
        if (sync2_r[i] == sync3_r[i])
          clean_r[i] <= sync3_r[i];
    end
  end

  // A level must survive three debounce samples, i.e. two to three clock periods.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_a_r <= '0;
      filt_b_r <= '0;
      filt_c_r <= '0;
      filt_r   <= '0;
    end
    else if (div_tick)
    begin
      filt_a_r <= clean_r;
      filt_b_r <= filt_a_r;
      filt_c_r <= filt_b_r;
      for (int i = 0; i < NPINS; i++)
        if (filt_a_r[i] == filt_b_r[i] && filt_b_r[i] == filt_c_r[i])
          filt_r[i] <= filt_c_r[i];
    end
  end

  // A stopped debounce clock would freeze the filter, so the filter is bypassed then.
  always_comb
  begin
    for (int g = 0; g < GROUPS; g++)
      for (int p = 0; p < PINS_PER_GROUP; p++)
      begin
        filtered[g*PINS_PER_GROUP+p] = (debounce_enable_r[g][p] && clk_run) ?
                                       filt_r[g*PINS_PER_GROUP+p] :
                                       clean_r[g*PINS_PER_GROUP+p];
        pin_level[g*PINS_PER_GROUP+p] = input_enable_bits_r[g][p] &&
                                        !peripheral_mode_r[g][p] &&
                                        filtered[g*PINS_PER_GROUP+p];
      end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      level_prev_r <= '0;
    else
      level_prev_r <= pin_level;
  end

  // Pad and peripheral routing, all registered.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pad_out       <= '0;
      pad_oe        <= '0;
      pad_pull_en   <= '0;
      pad_pull_up   <= '0;
      periph_in     <= '0;
      function_code <= '0;
    end
    else
    begin
      for (int g = 0; g < GROUPS; g++)
        for (int p = 0; p < PINS_PER_GROUP; p++)
        begin
          if (peripheral_mode_r[g][p])
          begin
            pad_out[g*PINS_PER_GROUP+p]     <= periph_out[g*PINS_PER_GROUP+p];
            pad_oe[g*PINS_PER_GROUP+p]      <= periph_oe[g*PINS_PER_GROUP+p];
            pad_pull_en[g*PINS_PER_GROUP+p] <= 1'b0;
            periph_in[g*PINS_PER_GROUP+p]   <= clean_r[g*PINS_PER_GROUP+p];
            function_code[(g*PINS_PER_GROUP+p)*FN_W +: FN_W] <= function_sel_r[g][p*FN_W +: FN_W];
          end
          else
          begin
            pad_out[g*PINS_PER_GROUP+p]     <= out_level_r[g][p];
            pad_oe[g*PINS_PER_GROUP+p]      <= output_enable_bits_r[g][p];
            pad_pull_en[g*PINS_PER_GROUP+p] <= pull_enable_r[g][p] &&
                                               !output_enable_bits_r[g][p];
            periph_in[g*PINS_PER_GROUP+p]   <= 1'b0;
            function_code[(g*PINS_PER_GROUP+p)*FN_W +: FN_W] <= 2'h0;
          end
          pad_pull_up[g*PINS_PER_GROUP+p] <= pull_direction_r[g][p];
        end
    end
  end

  // Per-group registers; writes take effect on the accepted edge.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int g = 0; g < GROUPS; g++)
      begin
        out_level_r[g]          <= 8'h00;
        input_enable_bits_r[g]  <= 8'h00;
        output_enable_bits_r[g] <= 8'h00;
        pull_direction_r[g]     <= 8'h00;
        pull_enable_r[g]        <= 8'h00;
        irq_edge_select_r[g]    <= 8'h00;
        pin_irq_enable_r[g]     <= 8'h00;
        debounce_enable_r[g]    <= 8'h00;
        peripheral_mode_r[g]    <= 8'h00;
        function_sel_r[g]       <= 16'h0000;
      end
    end
    else if (ack_r && avs_write && grp_hit)
    begin
      for (int g = 0; g < GROUPS; g++)
        if (grp_idx == 8'(g))
          case (reg_ofs)
            OFS_DATA:
              if (avs_byteenable[1])
                out_level_r[g] <= wdat[15:8];
            OFS_IO_ENABLE:
            begin
              if (avs_byteenable[1])
                input_enable_bits_r[g] <= wdat[15:8];
              if (avs_byteenable[0])
                output_enable_bits_r[g] <= wdat[7:0];
            end
            OFS_PULL:
            begin
              if (avs_byteenable[1])
                pull_direction_r[g] <= wdat[15:8];
              if (avs_byteenable[0])
                pull_enable_r[g] <= wdat[7:0];
            end
            OFS_IRQ_CTRL:
            begin
              if (avs_byteenable[1])
                irq_edge_select_r[g] <= wdat[15:8];
              if (avs_byteenable[0])
                pin_irq_enable_r[g] <= wdat[7:0];
            end
            OFS_DEBOUNCE:
              if (avs_byteenable[0])
                debounce_enable_r[g] <= wdat[7:0];
            OFS_MODE:
              if (avs_byteenable[0])
                peripheral_mode_r[g] <= wdat[7:0];
            OFS_FUNCTION:
              function_sel_r[g] <= (function_sel_r[g] & ~wmask) | (wdat & wmask);
            default:
              ;
          endcase
    end
  end

  // Flags: a selected edge sets, a written one clears, and the set wins.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int g = 0; g < GROUPS; g++)
        pin_irq_flag_r[g] <= 8'h00;
    end
    else
    begin
      for (int g = 0; g < GROUPS; g++)
        for (int p = 0; p < PINS_PER_GROUP; p++)
        begin
          if (level_prev_r[g*PINS_PER_GROUP+p] != pin_level[g*PINS_PER_GROUP+p] &&
              pin_level[g*PINS_PER_GROUP+p] != irq_edge_select_r[g][p] &&
              IRQ_GROUPS[g])
            pin_irq_flag_r[g][p] <= 1'b1;
          else if (ack_r && avs_write && grp_idx == 8'(g) && reg_ofs == OFS_IRQ_FLAGS &&
                   avs_byteenable[0] && wdat[p])
            pin_irq_flag_r[g][p] <= 1'b0;
        end
    end
  end

  // Clock control is write protected.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      clk_cfg_r <= '0;
    else if (ack_r && avs_write && avs_address == ADDR_CLOCK_CTRL && protect_unlocked)
    begin
      if (avs_byteenable[1])
        clk_cfg_r.debug_run <= wdat[DBG_BIT];
      if (avs_byteenable[0])
      begin
        clk_cfg_r.divider <= wdat[DIV_LSB +: DIV_W];
        clk_cfg_r.key_cfg <= wdat[KEY_LSB +: 2];
        if (SRC_PRESENT[wdat[SRC_LSB +: 2]])
          clk_cfg_r.source <= wdat[SRC_LSB +: 2];
      end
    end
  end

  always_comb
  begin
    for (int g = 0; g < GROUPS; g++)
      sum_bits[g] = IRQ_GROUPS[g] && |(pin_irq_flag_r[g] & pin_irq_enable_r[g]);
  end

  // Read mux; reserved and unmapped bits read as zero.
  always_comb
  begin
    rdata_nxt = UNMAPPED_READ;
    if (avs_address == ADDR_CLOCK_CTRL)
      rdata_nxt[15:0] = {7'h00, clk_cfg_r.debug_run, clk_cfg_r.divider,
                         clk_cfg_r.key_cfg, clk_cfg_r.source};
    else if (avs_address == ADDR_GROUP_SUM)
      rdata_nxt[GROUPS-1:0] = sum_bits;
    else if (grp_hit)
    begin
      for (int g = 0; g < GROUPS; g++)
        if (grp_idx == 8'(g))
          case (reg_ofs)
            OFS_DATA:      rdata_nxt[15:0] = {out_level_r[g], level_prev_r[g*8 +: 8]};
            OFS_IO_ENABLE: rdata_nxt[15:0] = {input_enable_bits_r[g], output_enable_bits_r[g]};
            OFS_PULL:      rdata_nxt[15:0] = {pull_direction_r[g], pull_enable_r[g]};
            OFS_IRQ_FLAGS: rdata_nxt[15:0] = {8'h00, pin_irq_flag_r[g]};
            OFS_IRQ_CTRL:  rdata_nxt[15:0] = {irq_edge_select_r[g], pin_irq_enable_r[g]};
            OFS_DEBOUNCE:  rdata_nxt[15:0] = {8'h00, debounce_enable_r[g]};
            OFS_MODE:      rdata_nxt[15:0] = {8'h00, peripheral_mode_r[g]};
            OFS_FUNCTION:  rdata_nxt[15:0] = function_sel_r[g];
            default:       rdata_nxt = UNMAPPED_READ;
          endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= UNMAPPED_READ;
    else if (req && avs_read)
      avs_readdata <= rdata_nxt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_out <= '0;
    else
      irq_out <= sum_bits;
  end

  // Key-entry reset looks at group 0 levels, filtered where debounce is enabled and the debounce clock runs.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      key_reset_req <= 1'b0;
    else
      case (clk_cfg_r.key_cfg)
        KEY_TWO:   key_reset_req <= ~|filtered[1:0];
        KEY_THREE: key_reset_req <= ~|filtered[2:0];
        KEY_FOUR:  key_reset_req <= ~|filtered[3:0];
        default:   key_reset_req <= 1'b0;
      endcase
  end

endmodule // port_group_control

/* File: sim/port_group_sva.sv */
// Checker for the bus handshake, reset state and pad outputs of the port group controller.
`timescale 1ns/1ps

module port_group_sva #(
  parameter int GROUPS = 4,
  parameter int N      = GROUPS * 8
) (
  input wire logic                             clk,
  input wire logic                             arst_n,
  input wire logic [port_group_pkg::ADDR_W-1:0] avs_address,
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic [31:0]                      avs_readdata,
  input wire logic                             avs_waitrequest,
  input wire logic [N-1:0]                     pad_oe,
  input wire logic [N-1:0]                     pad_pull_en,
  input wire logic [GROUPS-1:0]                irq_out,
  input wire logic                             key_reset_req
);
  import port_group_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ack;
  assign ack = avs_read && !avs_waitrequest;

  property p_wait_once; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_once: assert property (p_wait_once) else $error("waitrequest low twice");
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer after one wait");
  property p_idle; !(avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  property p_top_zero; ack |-> avs_readdata[31:16] == 16'h0000; endproperty
  a_top_zero: assert property (p_top_zero) else $error("upper read half not zero");
  property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_flag_hi;
    ack && avs_address[4:0] == OFS_IRQ_FLAGS[4:0] && int'(avs_address) < GROUPS * 32
      |-> avs_readdata[15:8] == 8'h00;
  endproperty
  a_flag_hi: assert property (p_flag_hi) else $error("flag upper byte set");
  property p_sum_hi; ack && avs_address == ADDR_GROUP_SUM |-> avs_readdata[15:GROUPS] == '0;
  endproperty
  a_sum_hi: assert property (p_sum_hi) else $error("summary spare bits set");
  property p_pull; (pad_oe & pad_pull_en) == '0; endproperty
  a_pull: assert property (p_pull) else $error("pull on a driven pad");
  property p_rst;
    !$past(arst_n) |-> pad_oe == '0 && pad_pull_en == '0 && irq_out == '0 && !key_reset_req;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet after reset");
  c_irq: cover property (irq_out != '0);
  c_key: cover property (key_reset_req);
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule // port_group_sva

bind port_group_control port_group_sva #(.GROUPS(GROUPS)) u_sva (
  .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .irq_out(irq_out),
  .key_reset_req(key_reset_req));

/* File: sim/pin_model.sv */
// Pin model that resolves each pad from the device drive, an outside driver and the pulls.
`timescale 1ns/1ps

module pin_model #(
  parameter int N = 32
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pull_en,
  input  wire logic [N-1:0] pad_pull_up,
  input  wire logic [N-1:0] ext_val,
  input  wire logic [N-1:0] ext_en,
  output logic      [N-1:0] pad_in
);
  logic [N-1:0] float_r = '0;

  // A floating pad wanders every cycle so no test can lean on a settled level.
  always_ff @(posedge clk)
    float_r <= ~float_r;

  always_comb
    for (int i = 0; i < N; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pad_pull_en[i] ? pad_pull_up[i] : float_r[i];
endmodule // pin_model

/* File: sim/testbench.sv */
// Self-checking bench for the port group controller.
`timescale 1ns/1ps

module testbench;
  import port_group_pkg::*;
  localparam int N = 32;
  logic          clk              = 1'b0;
  logic          arst_n           = 1'b0;
  logic [7:0]    avs_address      = 8'h00;
  logic          avs_read         = 1'b0;
  logic          avs_write        = 1'b0;
  logic [31:0]   avs_writedata    = 32'h0000_0000;
  logic          protect_unlocked = 1'b0;
  logic [N-1:0]  periph_out       = '0;
  logic [N-1:0]  periph_oe        = '0;
  logic [N-1:0]  ext_val          = '0;
  logic [N-1:0]  ext_en           = '0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic [N-1:0]  pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, periph_in;
  logic [2*N-1:0] function_code;
  logic [3:0]    irq_out;
  logic          key_reset_req;
  int            error_cnt        = 0;
  int            total_checks     = 0;
  int            cycles           = 0;

  port_group_control u_dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .protect_unlocked(protect_unlocked), .debug_mode(1'b0), .source_ticks(4'hF),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .function_code(function_code), .irq_out(irq_out),
    .key_reset_req(key_reset_req));

  pin_model #(.N(N)) u_pins (
    .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  always #2 clk = ~clk;

  task automatic results;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      results;
    end
  end

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    if (g !== e)
      error_cnt++;
  endtask

  // The request is held until a rising edge samples waitrequest low; data is taken there.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    check(nm, e, q);
  endtask

  function automatic logic [7:0] ra(input int g, input logic [7:0] o);
    return 8'(g) * GROUP_STRIDE + o;
  endfunction

  // Covers the pin synchronisers with margin.
  task automatic settle;
    repeat (12) @(posedge clk);
  endtask

  task automatic t_reset;
    for (int o = 0; o < 32; o += 4)
      rdc(ra(0, 8'(o)), 16'h0000, "group register");
    rdc(ADDR_CLOCK_CTRL, 16'h0000, "clock control");
    wr(8'h80, 16'hFFFF);
    rdc(8'h80, 16'h0000, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_pins;
    wr(ra(3, OFS_PULL), 16'h3CFF);
    wr(ra(3, OFS_IO_ENABLE), 16'h0F00);
    settle;
    check("pulls", 16'hFF3C, {pad_pull_en[31:24], pad_pull_up[31:24]});
    rdc(ra(3, OFS_DATA), 16'h000C, "pulled input");
    wr(ra(3, OFS_DATA), 16'hA500);
    settle;
    check("drive while off", 16'h0000, {8'h00, pad_oe[31:24]});
    wr(ra(3, OFS_IO_ENABLE), 16'hFFFF);
    settle;
    check("drive", 16'hFFA5, {pad_oe[31:24], pad_out[31:24]});
    check("pull while driving", 16'h0000, {8'h00, pad_pull_en[31:24]});
    rdc(ra(3, OFS_DATA), 16'hA5A5, "driven readback");
    $display("test pins done");
  endtask

  task automatic t_irq;
    ext_en[15:8]  <= 8'hFF;
    ext_val[15:8] <= 8'h02;
    wr(ra(1, OFS_IO_ENABLE), 16'hFF00);
    settle;
    wr(ra(1, OFS_IRQ_FLAGS), 16'h00FF);
    wr(ra(1, OFS_IRQ_CTRL), 16'h0201);
    ext_val[15:8] <= 8'h01;
    settle;
    rdc(ra(1, OFS_IRQ_FLAGS), 16'h0003, "flags");
    rdc(ADDR_GROUP_SUM, 16'h0002, "summary");
    check("irq", 16'h0002, {12'h000, irq_out});
    wr(ra(1, OFS_IRQ_FLAGS), 16'h0000);
    rdc(ra(1, OFS_IRQ_FLAGS), 16'h0003, "zero write");
    wr(ra(1, OFS_IRQ_FLAGS), 16'h0001);
    rdc(ra(1, OFS_IRQ_FLAGS), 16'h0002, "cleared");
    rdc(ADDR_GROUP_SUM, 16'h0000, "summary cleared");
    check("irq off", 16'h0000, {12'h000, irq_out});
    $display("test irq done");
  endtask

  task automatic t_periph;
    periph_out[23:16] <= 8'h5A;
    periph_oe[23:16]  <= 8'hFF;
    wr(ra(2, OFS_DATA), 16'hFF00);
    wr(ra(2, OFS_IO_ENABLE), 16'hFF00);
    wr(ra(2, OFS_MODE), 16'h00FF);
    wr(ra(2, OFS_FUNCTION), 16'hE4E4);
    settle;
    check("periph drive", 16'hFF5A, {pad_oe[23:16], pad_out[23:16]});
    check("codes", 16'hE4E4, function_code[47:32]);
    check("periph input", 16'h005A, {8'h00, periph_in[23:16]});
    rdc(ra(2, OFS_DATA), 16'hFF00, "input hidden");
    wr(ra(2, OFS_MODE), 16'h0000);
    settle;
    check("codes in gpio", 16'h0000, function_code[47:32]);
    $display("test periph done");
  endtask

  task automatic t_clk;
    wr(ADDR_CLOCK_CTRL, 16'h01FF);
    rdc(ADDR_CLOCK_CTRL, 16'h0000, "locked write");
    protect_unlocked <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CLOCK_CTRL, 16'(s));
      rdc(ADDR_CLOCK_CTRL, 16'(s), "source");
    end
    wr(ADDR_CLOCK_CTRL, 16'hFFFF);
    rdc(ADDR_CLOCK_CTRL, 16'h01FF, "clock fields");
    protect_unlocked <= 1'b0;
    wr(ADDR_CLOCK_CTRL, 16'h0000);
    rdc(ADDR_CLOCK_CTRL, 16'h01FF, "still locked");
    $display("test clock done");
  endtask

  task automatic t_key;
    ext_en[7:0]  <= 8'h0F;
    ext_val[7:0] <= 8'h0F;
    wr(ra(0, OFS_IO_ENABLE), 16'h0F00);
    protect_unlocked <= 1'b1;
    for (int k = 1; k < 4; k++)
    begin
      wr(ADDR_CLOCK_CTRL, 16'(k << 2));
      ext_val[7:0] <= 8'h0F & ~8'((1 << k) - 1);
      settle;
      check("one pin high", 16'h0000, {15'h0000, key_reset_req});
      ext_val[7:0] <= 8'h0F & ~8'((2 << k) - 1);
      settle;
      check("all low", 16'h0001, {15'h0000, key_reset_req});
      ext_val[7:0] <= 8'h0F;
      settle;
    end
    wr(ADDR_CLOCK_CTRL, 16'h0000);
    ext_val[7:0] <= 8'h00;
    settle;
    check("key off", 16'h0000, {15'h0000, key_reset_req});
    $display("test key done");
  endtask

  // Divider 2 gives a debounce tick every fourth clock, so a short low must be rejected.
  task automatic t_filter;
    logic seen;
    seen = 1'b0;
    wr(ra(0, OFS_DEBOUNCE), 16'h000F);
    wr(ADDR_CLOCK_CTRL, 16'h002C);
    ext_val[7:0] <= 8'h0F;
    repeat (40) @(posedge clk);
    ext_val[7:0] <= 8'h00;
    repeat (3) @(posedge clk);
    ext_val[7:0] <= 8'h0F;
    repeat (40)
    begin
      @(posedge clk);
      seen = seen | key_reset_req;
    end
    check("short low", 16'h0000, {15'h0000, seen});
    ext_val[7:0] <= 8'h00;
    repeat (6) @(posedge clk);
    check("low too young", 16'h0000, {15'h0000, key_reset_req});
    repeat (40) @(posedge clk);
    check("long low", 16'h0001, {15'h0000, key_reset_req});
    $display("test filter done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_pins;
    t_irq;
    t_periph;
    t_clk;
    t_key;
    t_filter;
    results;
  end
endmodule // testbench
